// ==== bench/sdw_bench.sv ====
// Self-checking bench of the DRAM write and self refresh block
`timescale 1ns/1ps
`default_nettype none
module sdw_bench;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, lck = 1'b0, quiet = 1'b0;
   logic        cke, wv, refp, sref, dll, perr;
   logic [3:0]  cmd, add_lat = 4'h0, wlat = 4'h5;
   logic [13:0] addr;
   logic [2:0]  ba, wbank;
   logic [15:0] dq, wdata;
   logic [1:0]  mask, keep, field = 2'h0;
   logic [9:0]  wcol;
   logic [7:0]  bopen;
   logic [30:0] expq [$];
   int          fail_count = 0, num_checks = 0, refs = 0;
   always #2.5 clk_i = ~clk_i;
   initial #13 forever #40 lck = ~lck;
   sdw_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_ck_i(lck),
      .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]),
      .we_n_i(cmd[0]), .addr_i(addr), .ba_i(ba), .dq_i(dq),
      .write_mask_input_i(mask), .burst_field_i(field),
      .additive_lat_i(add_lat), .write_lat_i(wlat), .wr_valid_o(wv),
      .wr_data_o(wdata), .wr_keep_o(keep), .wr_bank_o(wbank),
      .wr_col_o(wcol), .refresh_pulse_o(refp), .bank_open_o(bopen),
      .self_refresh_o(sref), .dll_enabled_o(dll), .protocol_err_o(perr));
   sdw_ctl_model ctl (.link_ck_i(lck), .cke_o(cke), .cmd_o(cmd),
      .addr_o(addr), .ba_o(ba), .dq_o(dq), .mask_o(mask));
   task automatic check(input logic [30:0] seen, input logic [30:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   function automatic int beats(input logic [1:0] f, input logic chop);
      if (f == sdw_pkg::BL_FIXED4) return 2;
      return (f == sdw_pkg::BL_PER_CMD && !chop) ? 2 : 4;
   endfunction : beats
   always @(negedge clk_i) begin
      if (refp === 1'b1) refs++;
      if (wv === 1'b1 && !quiet)
         check({wdata, keep, wbank, wcol},
               expq.size() > 0 ? expq.pop_front() : 31'h7FFFFFFF);
   end
   task automatic wr(input logic [1:0] f, input logic chop);
      logic [2:0] b;
      logic [9:0] c;
      int n;
      b = 3'($urandom);
      c = 10'($urandom);
      n = beats(f, chop);
      @(negedge clk_i);
      field <= f;
      add_lat <= f[0] ? 4'($urandom_range(2)) : 4'h0;
      wlat <= f[0] ? 4'(5 + $urandom_range(1)) : 4'h5;
      for (int k = 0; k < 4; k++) begin
         ctl.dat[k] = 16'($urandom);
         ctl.msk[k] = 2'($urandom);
         if (k < n)
            expq.push_back({ctl.dat[k], ~ctl.msk[k], b, c + 10'(2 * k)});
      end
      repeat (3) @(negedge lck); // Settings cross to the link clock
      ctl.issue(sdw_pkg::CMD_WRITE, {1'b0, chop, 2'h0, c}, b, 1'b1);
      ctl.burst(int'(wlat) + int'(add_lat));
      repeat (40) @(negedge clk_i);
      check(31'(expq.size()), 31'h0);
   endtask : wr
   initial begin
      void'($urandom(32'h31E2));
      repeat (60) @(negedge clk_i);
      rst_n_i <= 1'b1;
      repeat (6) @(negedge lck);
      check({dll, sref, perr, bopen}, 31'h400);
      for (int b = 0; b < 8; b++)
         ctl.issue(sdw_pkg::CMD_ACT, 14'h0000, 3'(b), 1'b1);
      for (int t = 0; t < 8; t++)
         wr(2'(t), t[2]);
      ctl.issue(sdw_pkg::CMD_PRE, 14'h0000, 3'h3, 1'b1);
      repeat (2) @(negedge lck);
      check(31'(bopen), 31'hF7);
      ctl.issue(sdw_pkg::CMD_PRE, 14'h0400, 3'h5, 1'b1);
      ctl.issue(sdw_pkg::CMD_REF, 14'h0000, 3'h0, 1'b1);
      ctl.issue(sdw_pkg::CMD_REF, 14'h0000, 3'h0, 1'b0);
      ctl.issue(sdw_pkg::CMD_ACT, 14'h0000, 3'h2, 1'b0);
      repeat (2) @(negedge lck);
      check({bopen, sref, dll, 21'(refs)}, {10'h002, 21'h2});
      ctl.issue(4'hF, 14'h0000, 3'h0, 1'b1);
      repeat (3) @(negedge lck);
      ctl.issue(sdw_pkg::CMD_ACT, 14'h0000, 3'h1, 1'b1);
      repeat (2) @(negedge lck);
      check({perr, bopen, sref, dll}, 31'h009);
      quiet = 1'b1;
      ctl.issue(sdw_pkg::CMD_WRITE, 14'h0000, 3'h0, 1'b1);
      repeat (2) @(negedge lck);
      check(31'(perr), 31'h1);
      test_done();
   end
   initial begin
      #400000;
      fail_count++;
      test_done();
   end
endmodule : sdw_bench
`default_nettype wire

// ==== bench/sdw_ctl_model.sv ====
// Memory controller model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module sdw_ctl_model (
   input  wire logic        link_ck_i,
   output logic             cke_o = 1'b1,
   output logic [3:0]       cmd_o = 4'hF,
   output logic [13:0]      addr_o = 14'h0000,
   output logic [2:0]       ba_o = 3'h0,
   output logic [15:0]      dq_o = 16'h0000,
   output logic [1:0]       mask_o = 2'h0
);
   logic [15:0] dat [4];
   logic [1:0]  msk [4];
   // One link clock of command, then deselect
   task automatic issue(input logic [3:0] c, input logic [13:0] a,
                        input logic [2:0] b, input logic k);
      @(negedge link_ck_i);
      cmd_o <= c;
      addr_o <= a;
      ba_o <= b;
      cke_o <= k;
      @(negedge link_ck_i);
      cmd_o <= 4'hF;
      addr_o <= ~addr_o;
      ba_o <= ~ba_o;
   endtask : issue
   // Pairs from edge wl on; lines inverted once released
   task automatic burst(input int wl);
      repeat (wl - 1) @(negedge link_ck_i);
      for (int k = 0; k < 4; k++) begin
         dq_o <= dat[k];
         mask_o <= msk[k];
         @(negedge link_ck_i);
      end
      dq_o <= ~dq_o;
      mask_o <= ~mask_o;
   endtask : burst
endmodule : sdw_ctl_model
`default_nettype wire

// ==== src/sdw_pkg.sv ====
// Shared constants and types of the DRAM write and self refresh block
package sdw_pkg;
   // Widths
   localparam int BANKS  = 8;
   localparam int BANK_W = 3;
   localparam int ADDR_W = 14;
   localparam int COL_W  = 10;
   localparam int EL_W   = 8;
   localparam int ELS    = 2;
   localparam int DQ_W   = EL_W * ELS;
   localparam int LAT_W  = 5;
   localparam int PIPE_D = 32;
   localparam int CFG_W  = 10;
   // Burst-length field of mode_register_zero
   localparam logic [1:0] BL_FIXED8  = 2'h0;
   localparam logic [1:0] BL_PER_CMD = 2'h1;
   localparam logic [1:0] BL_FIXED4  = 2'h2;
   // Address bit positions
   localparam int CHOP_BIT     = 12;
   localparam int ALL_BANK_BIT = 10;
   // Clocks of a burst after the first, two elements per clock
   localparam logic [1:0] CLKS_FULL = 2'h3;
   localparam logic [1:0] CLKS_CHOP = 2'h1;
   localparam logic [1:0] CLKS_NONE = 2'h0;
   localparam logic [COL_W-1:0] COL_STEP = 10'h002;
   // Commands as {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_REF   = 4'h1;
   // Pending write entry layout
   localparam int ENT_W         = 15;
   localparam int ENT_VALID_BIT = 14;
   localparam int ENT_CHOP_BIT  = 13;
   localparam int ENT_BANK_LSB  = 10;
   // Reset values
   localparam logic [ENT_W-1:0] ENT_EMPTY  = 15'h0000;
   localparam logic [BANKS-1:0] BANK_IDLE  = 8'h00;
   localparam logic [CFG_W-1:0] CFG_RESET  = 10'h005;
   localparam logic [DQ_W-1:0]  DATA_RESET = 16'h0000;
   localparam logic [1:0]       TGL_RESET  = 2'h0;

   typedef enum logic [1:0] {
      SDW_PWR_AWAKE,
      SDW_PWR_SELF_REF,
      SDW_PWR_DLL_RESET
   } sdw_pwr_type;
endpackage : sdw_pkg

// ==== src/sdw_sys_rx.sv ====
// System-clock side of the link crossing
`timescale 1ns/1ps
`default_nettype none
module sdw_sys_rx (
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   sdw_xfer_if.sys                           x,
   output logic                              wr_valid_o,
   output logic [sdw_pkg::DQ_W-1:0]          wr_data_o,
   output logic [sdw_pkg::ELS-1:0]           wr_keep_o,
   output logic [sdw_pkg::BANK_W-1:0]        wr_bank_o,
   output logic [sdw_pkg::COL_W-1:0]         wr_col_o,
   output logic                              refresh_pulse_o,
   output logic [sdw_pkg::BANKS-1:0]         bank_open_o,
   output logic                              self_refresh_o,
   output logic                              dll_enabled_o,
   output logic                              protocol_err_o
);
   localparam int STAT_W = sdw_pkg::BANKS + 3;

   logic [STAT_W-1:0] stat_s1_reg;
   logic [1:0]        tgl_s1_reg;
   logic [1:0]        tgl_s2_reg;
   logic [1:0]        tgl_s3_reg;
   logic [1:0]        tgl_edge;

   assign tgl_edge = tgl_s2_reg ^ tgl_s3_reg;

   ////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stat_s1_reg <= '0;
         tgl_s1_reg  <= sdw_pkg::TGL_RESET;
         tgl_s2_reg  <= sdw_pkg::TGL_RESET;
         tgl_s3_reg  <= sdw_pkg::TGL_RESET;
         bank_open_o    <= sdw_pkg::BANK_IDLE;
         self_refresh_o <= 1'b0;
         dll_enabled_o  <= 1'b0;
         protocol_err_o <= 1'b0;
      end else begin
         stat_s1_reg <= {x.bank_open, x.self_ref, x.dll_on, x.prot_err};
         {bank_open_o, self_refresh_o, dll_enabled_o, protocol_err_o}
            <= stat_s1_reg;
         tgl_s1_reg <= {x.word_tgl, x.ref_tgl};
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Word capture; link word is held a full link clock, far past sync
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_valid_o      <= 1'b0;
         refresh_pulse_o <= 1'b0;
         wr_data_o       <= sdw_pkg::DATA_RESET;
         wr_keep_o       <= '0;
         wr_bank_o       <= '0;
         wr_col_o        <= '0;
      end else begin
         wr_valid_o      <= tgl_edge[1];
         refresh_pulse_o <= tgl_edge[0];
         if (tgl_edge[1]) begin
            wr_data_o <= x.word_data;
            wr_keep_o <= x.word_keep;
            wr_bank_o <= x.word_bank;
            wr_col_o  <= x.word_col;
         end
      end
   end

   valid_pulse_a : assert property (@(posedge clk_i)
      disable iff (!rst_n_i)
      wr_valid_o |=> !wr_valid_o)
      else $error("write word valid longer than one cycle");
endmodule : sdw_sys_rx
`default_nettype wire

// ==== src/sdw_top.sv ====
// DRAM device write burst, precharge and self refresh command logic
//
// What this block does
// - Field 00, or 01 with chop high: eight beats
// - Field 01 with chop low: four-beat chop
// - Field 10 always gives four-beat chop
// - Each write carries its own bank and column
// - Precharge all banks or the selected bank
// - Precharged bank idle until activated again
// - Refresh with clock enable low enters self refresh
// - Loop off on entry, reset on exit
// - In self refresh only clock enable matters
// - Internal refresh starts right at entry
// - Write data starts additive plus write latency
// - Mask high leaves the element unwritten
`timescale 1ns/1ps
`default_nettype none
module sdw_top (
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   input  wire logic                         link_ck_i,
   input  wire logic                         cke_i,
   input  wire logic                         cs_n_i,
   input  wire logic                         ras_n_i,
   input  wire logic                         cas_n_i,
   input  wire logic                         we_n_i,
   input  wire logic [sdw_pkg::ADDR_W-1:0]   addr_i,
   input  wire logic [sdw_pkg::BANK_W-1:0]   ba_i,
   input  wire logic [sdw_pkg::DQ_W-1:0]     dq_i,
   input  wire logic [sdw_pkg::ELS-1:0]      write_mask_input_i,
   input  wire logic [1:0]                   burst_field_i,
   input  wire logic [3:0]                   additive_lat_i,
   input  wire logic [3:0]                   write_lat_i,
   output logic                              wr_valid_o,
   output logic [sdw_pkg::DQ_W-1:0]          wr_data_o,
   output logic [sdw_pkg::ELS-1:0]           wr_keep_o,
   output logic [sdw_pkg::BANK_W-1:0]        wr_bank_o,
   output logic [sdw_pkg::COL_W-1:0]         wr_col_o,
   output logic                              refresh_pulse_o,
   output logic [sdw_pkg::BANKS-1:0]         bank_open_o,
   output logic                              self_refresh_o,
   output logic                              dll_enabled_o,
   output logic                              protocol_err_o
);
   localparam int EW = sdw_pkg::ENT_W;
   localparam int VB = sdw_pkg::ENT_VALID_BIT;
   localparam int CB = sdw_pkg::ENT_CHOP_BIT;
   localparam int BL = sdw_pkg::ENT_BANK_LSB;

   logic                           lrst_s1_reg;
   logic                           lrst_n_reg;
   logic [sdw_pkg::CFG_W-1:0]      cfg_s1_reg;
   logic [sdw_pkg::CFG_W-1:0]      cfg_reg;
   logic [1:0]                     cfg_bl;
   logic [sdw_pkg::LAT_W-1:0]      wl_now;
   logic [sdw_pkg::LAT_W-1:0]      ins_idx;
   logic [3:0]                     cmd;
   logic                           cke_prev_reg;
   logic                           cmd_ok;
   logic                           wr_accept;
   logic                           act_accept;
   logic                           pre_accept;
   logic                           ref_accept;
   logic                           sre_accept;
   logic                           chop_now;
   logic [EW-1:0]                  new_ent;
   logic [EW-1:0]                  head;
   sdw_pkg::sdw_pwr_type           pwr_state_reg;
   logic                           dll_on_reg;
   logic [sdw_pkg::BANKS-1:0]      bank_open_reg;
   logic                           err_reg;
   logic                           ref_tgl_reg;
   logic [1:0]                     left_reg;
   logic [sdw_pkg::BANK_W-1:0]     cur_bank_reg;
   logic [sdw_pkg::COL_W-1:0]      cur_col_reg;
   logic                           beat_now;
   logic                           word_tgl_reg;
   logic [sdw_pkg::DQ_W-1:0]       word_data_reg;
   logic [sdw_pkg::ELS-1:0]        word_keep_reg;
   logic [sdw_pkg::BANK_W-1:0]     word_bank_reg;
   logic [sdw_pkg::COL_W-1:0]      word_col_reg;

   ////////////////////////////////////////////////////////////////////
   // Link-domain reset and configuration synchronisers
   always_ff @(posedge link_ck_i) begin
      lrst_s1_reg <= rst_n_i;
      lrst_n_reg  <= lrst_s1_reg;
   end

   // Quasi-static settings; change only while the link is idle
   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         cfg_s1_reg <= sdw_pkg::CFG_RESET;
         cfg_reg    <= sdw_pkg::CFG_RESET;
      end else begin
         cfg_s1_reg <= {burst_field_i, additive_lat_i, write_lat_i};
         cfg_reg    <= cfg_s1_reg;
      end
   end

   assign cfg_bl  = cfg_reg[9:8];
   assign wl_now  = {1'b0, cfg_reg[7:4]} + {1'b0, cfg_reg[3:0]};
   assign ins_idx = wl_now - 5'h01;

   ////////////////////////////////////////////////////////////////////
   // Command decode; nothing but clock enable counts when asleep
   assign cmd        = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
   assign cmd_ok     = (pwr_state_reg == sdw_pkg::SDW_PWR_AWAKE) &&
                       cke_prev_reg && cke_i;
   assign wr_accept  = cmd_ok && (cmd == sdw_pkg::CMD_WRITE);
   assign act_accept = cmd_ok && (cmd == sdw_pkg::CMD_ACT);
   assign pre_accept = cmd_ok && (cmd == sdw_pkg::CMD_PRE);
   assign ref_accept = cmd_ok && (cmd == sdw_pkg::CMD_REF);
   assign sre_accept = (pwr_state_reg == sdw_pkg::SDW_PWR_AWAKE) &&
                       cke_prev_reg && !cke_i &&
                       (cmd == sdw_pkg::CMD_REF);

   // Reserved field value 11 falls back to eight beats
   assign chop_now = (cfg_bl == sdw_pkg::BL_FIXED4) ||
                     ((cfg_bl == sdw_pkg::BL_PER_CMD) &&
                      !addr_i[sdw_pkg::CHOP_BIT]);

   assign new_ent = {1'b1, chop_now, ba_i,
                     addr_i[sdw_pkg::COL_W-1:0]};

   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         cke_prev_reg <= 1'b0;
      end else begin
         cke_prev_reg <= cke_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Power state: self refresh entry, exit and loop reset
   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         pwr_state_reg <= sdw_pkg::SDW_PWR_AWAKE;
      end else begin
         case (pwr_state_reg)
            sdw_pkg::SDW_PWR_AWAKE: begin
               if (sre_accept) begin
                  pwr_state_reg <= sdw_pkg::SDW_PWR_SELF_REF;
               end
            end
            sdw_pkg::SDW_PWR_SELF_REF: begin
               if (cke_i) begin
                  pwr_state_reg <= sdw_pkg::SDW_PWR_DLL_RESET;
               end
            end
            sdw_pkg::SDW_PWR_DLL_RESET: begin
               pwr_state_reg <= sdw_pkg::SDW_PWR_AWAKE;
            end
            default: begin
               pwr_state_reg <= sdw_pkg::SDW_PWR_AWAKE;
            end
         endcase
      end
   end

   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         dll_on_reg <= 1'b1;
      end else if (sre_accept) begin
         dll_on_reg <= 1'b0;
      end else if (pwr_state_reg == sdw_pkg::SDW_PWR_DLL_RESET) begin
         dll_on_reg <= 1'b1;
      end
   end

   // One internal refresh launched at the entry edge itself
   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         ref_tgl_reg <= 1'b0;
      end else if (sre_accept || ref_accept) begin
         ref_tgl_reg <= !ref_tgl_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Bank open state and sticky protocol error
   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         bank_open_reg <= sdw_pkg::BANK_IDLE;
      end else if (act_accept) begin
         bank_open_reg[ba_i] <= 1'b1;
      end else if (pre_accept) begin
         if (addr_i[sdw_pkg::ALL_BANK_BIT]) begin
            bank_open_reg <= sdw_pkg::BANK_IDLE;
         end else begin
            bank_open_reg[ba_i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         err_reg <= 1'b0;
      end else if (wr_accept && !bank_open_reg[ba_i]) begin
         err_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Pending writes, one slot per clock of write latency
   for (genvar i = 0; i < sdw_pkg::PIPE_D; i++) begin : g_pipe
      logic [EW-1:0] ent_reg;
      logic [EW-1:0] up;
      if (i == sdw_pkg::PIPE_D - 1) begin : g_top
         assign up = sdw_pkg::ENT_EMPTY;
      end else begin : g_mid
         assign up = g_pipe[i + 1].ent_reg;
      end
      always_ff @(posedge link_ck_i) begin
         if (!lrst_n_reg) begin
            ent_reg <= sdw_pkg::ENT_EMPTY;
         end else if (wr_accept && ins_idx == sdw_pkg::LAT_W'(i)) begin
            ent_reg <= new_ent;
         end else begin
            ent_reg <= up;
         end
      end
   end

   assign head = g_pipe[0].ent_reg;

   ////////////////////////////////////////////////////////////////////
   // Burst engine; a new head follows the last word without a gap
   assign beat_now = head[VB] || (left_reg != sdw_pkg::CLKS_NONE);

   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         left_reg     <= sdw_pkg::CLKS_NONE;
         cur_bank_reg <= '0;
         cur_col_reg  <= '0;
      end else if (head[VB]) begin
         left_reg     <= head[CB] ? sdw_pkg::CLKS_CHOP
                                  : sdw_pkg::CLKS_FULL;
         cur_bank_reg <= head[BL +: sdw_pkg::BANK_W];
         cur_col_reg  <= head[sdw_pkg::COL_W-1:0] + sdw_pkg::COL_STEP;
      end else if (left_reg != sdw_pkg::CLKS_NONE) begin
         left_reg    <= left_reg - 2'h1;
         cur_col_reg <= cur_col_reg + sdw_pkg::COL_STEP;
      end
   end

   // Word held for a full link clock while the toggle crosses
   always_ff @(posedge link_ck_i) begin
      if (!lrst_n_reg) begin
         word_tgl_reg  <= 1'b0;
         word_data_reg <= sdw_pkg::DATA_RESET;
         word_keep_reg <= '0;
         word_bank_reg <= '0;
         word_col_reg  <= '0;
      end else if (beat_now) begin
         word_tgl_reg  <= !word_tgl_reg;
         word_data_reg <= dq_i;
         word_keep_reg <= ~write_mask_input_i;
         word_bank_reg <= head[VB] ? head[BL +: sdw_pkg::BANK_W]
                                   : cur_bank_reg;
         word_col_reg  <= head[VB] ? head[sdw_pkg::COL_W-1:0]
                                   : cur_col_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Crossing to the system clock
   sdw_xfer_if xfer ();

   assign xfer.word_tgl  = word_tgl_reg;
   assign xfer.word_data = word_data_reg;
   assign xfer.word_keep = word_keep_reg;
   assign xfer.word_bank = word_bank_reg;
   assign xfer.word_col  = word_col_reg;
   assign xfer.ref_tgl   = ref_tgl_reg;
   assign xfer.bank_open = bank_open_reg;
   assign xfer.self_ref  = (pwr_state_reg == sdw_pkg::SDW_PWR_SELF_REF);
   assign xfer.dll_on    = dll_on_reg;
   assign xfer.prot_err  = err_reg;

   sdw_sys_rx u_sys_rx (
      .clk_i           (clk_i),
      .rst_n_i         (rst_n_i),
      .x               (xfer),
      .wr_valid_o      (wr_valid_o),
      .wr_data_o       (wr_data_o),
      .wr_keep_o       (wr_keep_o),
      .wr_bank_o       (wr_bank_o),
      .wr_col_o        (wr_col_o),
      .refresh_pulse_o (refresh_pulse_o),
      .bank_open_o     (bank_open_o),
      .self_refresh_o  (self_refresh_o),
      .dll_enabled_o   (dll_enabled_o),
      .protocol_err_o  (protocol_err_o)
   );

   ////////////////////////////////////////////////////////////////////
   // Checks
   full_burst_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      head[VB] && !head[CB] |=>
         left_reg == 2'h3 ##1 left_reg == 2'h2 ##1 left_reg == 2'h1)
      else $error("eight beat burst did not run four clocks");

   chop_burst_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      head[VB] && head[CB] |=> left_reg == 2'h1 ##1 !beat_now || head[VB])
      else $error("chopped burst did not run two clocks");

   fixed_chop_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      wr_accept && cfg_bl == 2'h2 && wl_now == 5'h05 |->
         ##5 head[VB] && head[CB])
      else $error("fixed chop setting not applied");

   write_lat_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      wr_accept && wl_now == 5'h05 |-> ##5 beat_now
         ##1 word_col_reg == $past(addr_i[9:0], 6))
      else $error("first write word not at write latency");

   prech_all_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      pre_accept && addr_i[10] |=> bank_open_reg == 8'h00)
      else $error("precharge all left a bank open");

   prech_one_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      pre_accept && !addr_i[10] |=>
         !bank_open_reg[$past(ba_i)] &&
         ((bank_open_reg | (8'h01 << $past(ba_i))) ==
          ($past(bank_open_reg) | (8'h01 << $past(ba_i)))))
      else $error("single bank precharge touched wrong bank");

   idle_bank_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      wr_accept && !bank_open_reg[ba_i] |=> err_reg)
      else $error("write to idle bank not flagged");

   sr_entry_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      sre_accept |=> pwr_state_reg == sdw_pkg::SDW_PWR_SELF_REF &&
         !dll_on_reg && ref_tgl_reg != $past(ref_tgl_reg))
      else $error("self refresh entry incomplete");

   sr_exit_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      pwr_state_reg == sdw_pkg::SDW_PWR_SELF_REF && cke_i |=>
         !dll_on_reg ##1 dll_on_reg &&
         pwr_state_reg == sdw_pkg::SDW_PWR_AWAKE)
      else $error("loop not reset on self refresh exit");

   sr_ignore_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      pwr_state_reg == sdw_pkg::SDW_PWR_SELF_REF |=>
         $stable(bank_open_reg) && $stable(g_pipe[4].ent_reg[VB]) ||
         g_pipe[4].ent_reg[VB] == g_pipe[5].ent_reg[VB])
      else $error("command acted on during self refresh");

   mask_keep_a : assert property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      beat_now |=> word_keep_reg == ~$past(write_mask_input_i))
      else $error("mask not turned into element enables");

   full_c : cover property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg) head[VB] && !head[CB]);
   chop_c : cover property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg) head[VB] && head[CB]);
   sre_c : cover property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg) sre_accept);
   back_c : cover property (@(posedge link_ck_i)
      disable iff (!lrst_n_reg)
      left_reg == 2'h1 ##1 head[VB]);
endmodule : sdw_top
`default_nettype wire

// ==== src/sdw_xfer_if.sv ====
// Bundle carried from the link domain to the system domain
`timescale 1ns/1ps
`default_nettype none
interface sdw_xfer_if;
   logic                         word_tgl;
   logic [sdw_pkg::DQ_W-1:0]     word_data;
   logic [sdw_pkg::ELS-1:0]      word_keep;
   logic [sdw_pkg::BANK_W-1:0]   word_bank;
   logic [sdw_pkg::COL_W-1:0]    word_col;
   logic                         ref_tgl;
   logic [sdw_pkg::BANKS-1:0]    bank_open;
   logic                         self_ref;
   logic                         dll_on;
   logic                         prot_err;
   modport link (output word_tgl, word_data, word_keep, word_bank,
                 word_col, ref_tgl, bank_open, self_ref, dll_on,
                 prot_err);
   modport sys  (input word_tgl, word_data, word_keep, word_bank,
                 word_col, ref_tgl, bank_open, self_ref, dll_on,
                 prot_err);
endinterface : sdw_xfer_if
`default_nettype wire
